/* File: rtl/acdp_pkg.sv */
// package: register map, field layout, reset values and timing counts
package acdp_pkg;

    localparam logic [15:0] ADDR_CHANNEL_SELECT  = 16'h0008;
    localparam logic [15:0] ADDR_POWER_CTRL_A    = 16'h003F;
    localparam logic [15:0] ADDR_POWER_CTRL_B    = 16'h0040;
    localparam logic [15:0] ADDR_CLK_DIV_RATIO   = 16'h0108;
    localparam logic [15:0] ADDR_HALF_PHASE_DLY  = 16'h010C;
    localparam logic [15:0] ADDR_CLK_DLY_MODE    = 16'h0110;
    localparam logic [15:0] ADDR_SUPERFINE_DLY   = 16'h0111;
    localparam logic [15:0] ADDR_FINE_DLY        = 16'h0112;
    localparam logic [15:0] ADDR_DUTY_STAB_A     = 16'h011C;
    localparam logic [15:0] ADDR_DUTY_STAB_B     = 16'h011E;
    localparam logic [15:0] ADDR_STBY_FILL_SEL   = 16'h0571;
    localparam logic [15:0] ADDR_REF_EXPORT      = 16'h18A6;
    localparam logic [15:0] ADDR_CM_EXPORT       = 16'h18E3;
    localparam logic [15:0] ADDR_DIODE_EXPORT    = 16'h18E6;

    localparam logic [7:0]  RST_CHANNEL_SELECT   = 8'h03;
    localparam logic [7:0]  RST_ZERO             = 8'h00;
    localparam logic [7:0]  RST_DUTY_STAB_ON     = 8'h01;

    // divider ratio field, sync phase field, sync enable bit
    localparam logic [1:0]  DIV_BY_1             = 2'h0;
    localparam logic [1:0]  DIV_BY_2             = 2'h1;
    localparam logic [1:0]  DIV_BY_4             = 2'h2;
    localparam int          DIV_SYNC_PHASE_LSB   = 4;
    localparam int          DIV_SYNC_EN_BIT      = 7;

    // delay mode field
    localparam logic [2:0]  DLY_MODE_OFF         = 3'h0;
    localparam logic [2:0]  DLY_MODE_SF_A        = 3'h2;
    localparam logic [2:0]  DLY_MODE_SF_B        = 3'h6;
    localparam int          DLY_MODE_192_BIT     = 2;
    localparam logic [7:0]  FINE_MAX_16          = 8'h0F;
    localparam logic [7:0]  FINE_MAX_192         = 8'hBF;
    localparam logic [7:0]  SUPERFINE_MAX        = 8'h7F;

    // power control, fill, export, duty stabilizer and diode fields
    localparam logic [1:0]  PWR_NORMAL           = 2'h0;
    localparam logic [1:0]  PWR_STANDBY          = 2'h2;
    localparam logic [1:0]  PWR_DOWN             = 2'h3;
    localparam logic [1:0]  PIN_FN_PDOWN         = 2'h0;
    localparam logic [1:0]  PIN_FN_STANDBY       = 2'h1;
    localparam int          FILL_K_BIT           = 7;
    localparam int          CM_EXPORT_BIT        = 6;
    localparam int          REF_EXPORT_BIT       = 0;
    localparam int          DUTY_STAB_EN_BIT     = 0;
    localparam logic [7:0]  DIODE_SMALL          = 8'h01;
    localparam logic [7:0]  DIODE_LARGE          = 8'h02;

    // datapath reset pulse length
    localparam logic [2:0]  DP_RST_CYCLES        = 3'h4;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } acdp_req_t;

    typedef struct packed {
        logic       half_en;
        logic       fine_en;
        logic       fine_192;
        logic [7:0] fine;
        logic       sfine_en;
        logic [7:0] sfine;
    } acdp_dly_t;

endpackage

/* File: rtl/acdp_ctrl.sv */
// module: sample clock divider, delay, stabilizer, power and export control
`timescale 1ns/1ps

module acdp_ctrl
#(
    parameter bit HIGH_GRADE = 1'b1
)
(
    // clock and reset
    input  wire  logic                    clk,
    input  wire  logic                    rst_n,
    // decoded register access from the serial control port
    input  wire  acdp_pkg::acdp_req_t     req,
    output logic [7:0]                    reg_rdata,
    // sample clock and alignment
    input  wire  logic                    sysref_in,
    output logic                          div_tick,
    output logic [1:0]                    div_phase,
    // per-channel sampling delay
    output acdp_pkg::acdp_dly_t [1:0]     ch_dly,
    output logic [1:0]                    duty_stabilizer_on,
    output logic                          dp_reset,
    // power control and link
    input  wire  logic                    power_control_pin,
    output logic                          link_up,
    output logic                          standby_active,
    output logic                          fill_k_chars,
    output logic                          power_down_state,
    // reference pin exports
    output logic [1:0]                    diode_export,
    output logic                          common_mode_voltage_on,
    output logic                          ref_export_on
);
    import acdp_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [7:0]       chsel;
        logic [7:0]       pwr_a;
        logic [7:0]       pwr_b;
        logic [7:0]       div_cfg;
        logic [7:0]       half;
        logic [1:0][7:0]  mode;
        logic [1:0][7:0]  sfine;
        logic [1:0][7:0]  fine;
        logic [7:0]       stab_a;
        logic [7:0]       stab_b;
        logic [7:0]       fill;
        logic [7:0]       refx;
        logic [7:0]       cmx;
        logic [7:0]       diode;
        logic [1:0]       div_cnt;
        logic             div_tick;
        logic [2:0]       dp_cnt;
        logic             dp_rst;
        logic             link_up;
        logic             stby;
        logic             fill_k;
        logic             pdown;
        logic [7:0]       rdata;
        acdp_dly_t [1:0]  dly;
        logic [1:0]       stab_on;
        logic [1:0]       diode_out;
        logic             cm_on;
        logic             ref_on;
    } acdp_state_t;

    acdp_state_t s_r;
    acdp_state_t s_nxt;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [1:0] div_last(input logic [1:0] code);
        case (code)
            DIV_BY_2: div_last = 2'h1;
            DIV_BY_4: div_last = 2'h3;
            default:  div_last = 2'h0;
        endcase
    endfunction

    function automatic logic sf_mode(input logic [7:0] m);
        sf_mode = (m[2:0] == DLY_MODE_SF_A) || (m[2:0] == DLY_MODE_SF_B);
    endfunction

    function automatic logic [7:0] clamp8(input logic [7:0] v,
                                          input logic [7:0] lim);
        clamp8 = (v > lim) ? lim : v;
    endfunction

    function automatic logic [7:0] stab_reset(input bit grade);
        stab_reset = grade ? RST_DUTY_STAB_ON : RST_ZERO;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // next state

    logic       ch_rd;
    logic [1:0] last;
    logic [1:0] sync_ph;
    logic       pd_now;
    logic       sb_now;
    logic       fine_on_edge;

    always_comb
    begin
        s_nxt        = s_r;
        ch_rd        = ~s_r.chsel[0];
        fine_on_edge = 1'b0;

        // register writes; per-channel ones follow the channel mask
        if (req.wr)
        begin
            case (req.addr)
                ADDR_CHANNEL_SELECT: s_nxt.chsel   = req.wdata;
                ADDR_POWER_CTRL_A:   s_nxt.pwr_a   = req.wdata;
                ADDR_POWER_CTRL_B:   s_nxt.pwr_b   = req.wdata;
                ADDR_CLK_DIV_RATIO:  s_nxt.div_cfg = req.wdata;
                ADDR_HALF_PHASE_DLY: s_nxt.half    = req.wdata;
                ADDR_DUTY_STAB_A:    s_nxt.stab_a  = req.wdata;
                ADDR_DUTY_STAB_B:    s_nxt.stab_b  = req.wdata;
                ADDR_STBY_FILL_SEL:  s_nxt.fill    = req.wdata;
                ADDR_REF_EXPORT:     s_nxt.refx    = req.wdata;
                ADDR_CM_EXPORT:      s_nxt.cmx     = req.wdata;
                ADDR_DIODE_EXPORT:   s_nxt.diode   = req.wdata;
                default:             s_nxt.chsel   = s_r.chsel;
            endcase
            for (int ch = 0; ch < 2; ch++)
            begin
                if (s_r.chsel[ch])
                begin
                    if (req.addr == ADDR_CLK_DLY_MODE)
                    begin
                        s_nxt.mode[ch] = req.wdata;
                        if (s_r.mode[ch][2:0] == DLY_MODE_OFF &&
                            req.wdata[2:0] != DLY_MODE_OFF)
                        begin
                            fine_on_edge = 1'b1;
                        end
                    end
                    if (req.addr == ADDR_SUPERFINE_DLY)
                    begin
                        s_nxt.sfine[ch] = req.wdata;
                    end
                    if (req.addr == ADDR_FINE_DLY)
                    begin
                        s_nxt.fine[ch] = req.wdata;
                    end
                end
            end
        end

        // read data, one cycle after the strobe; unmapped reads zero
        if (req.rd)
        begin
            case (req.addr)
                ADDR_CHANNEL_SELECT: s_nxt.rdata = s_r.chsel;
                ADDR_POWER_CTRL_A:   s_nxt.rdata = s_r.pwr_a;
                ADDR_POWER_CTRL_B:   s_nxt.rdata = s_r.pwr_b;
                ADDR_CLK_DIV_RATIO:  s_nxt.rdata = s_r.div_cfg;
                ADDR_HALF_PHASE_DLY: s_nxt.rdata = s_r.half;
                ADDR_CLK_DLY_MODE:   s_nxt.rdata = s_r.mode[ch_rd];
                ADDR_SUPERFINE_DLY:  s_nxt.rdata = s_r.sfine[ch_rd];
                ADDR_FINE_DLY:       s_nxt.rdata = s_r.fine[ch_rd];
                ADDR_DUTY_STAB_A:    s_nxt.rdata = s_r.stab_a;
                ADDR_DUTY_STAB_B:    s_nxt.rdata = s_r.stab_b;
                ADDR_STBY_FILL_SEL:  s_nxt.rdata = s_r.fill;
                ADDR_REF_EXPORT:     s_nxt.rdata = s_r.refx;
                ADDR_CM_EXPORT:      s_nxt.rdata = s_r.cmx;
                ADDR_DIODE_EXPORT:   s_nxt.rdata = s_r.diode;
                default:             s_nxt.rdata = RST_ZERO;
            endcase
        end

        // clock divider with sysref realignment
        last    = div_last(s_r.div_cfg[1:0]);
        sync_ph = s_r.div_cfg[DIV_SYNC_PHASE_LSB +: 2] & last;
        if (sysref_in && s_r.div_cfg[DIV_SYNC_EN_BIT])
        begin
            s_nxt.div_cnt = sync_ph;
        end
        else if (s_r.div_cnt >= last)
        begin
            s_nxt.div_cnt = 2'h0;
        end
        else
        begin
            s_nxt.div_cnt = s_r.div_cnt + 2'h1;
        end
        s_nxt.div_tick = (s_nxt.div_cnt == 2'h0);

        // delay outputs follow registers at once, no commit step
        for (int ch = 0; ch < 2; ch++)
        begin
            s_nxt.dly[ch].half_en  = s_nxt.half[ch];
            s_nxt.dly[ch].fine_en  =
                s_nxt.mode[ch][2:0] != DLY_MODE_OFF;
            s_nxt.dly[ch].fine_192 =
                s_nxt.mode[ch][DLY_MODE_192_BIT];
            s_nxt.dly[ch].fine     = !s_nxt.dly[ch].fine_en ? RST_ZERO :
                clamp8(s_nxt.fine[ch], s_nxt.dly[ch].fine_192 ?
                       FINE_MAX_192 : FINE_MAX_16);
            s_nxt.dly[ch].sfine_en = sf_mode(s_nxt.mode[ch]);
            s_nxt.dly[ch].sfine    = s_nxt.dly[ch].sfine_en ?
                clamp8(s_nxt.sfine[ch], SUPERFINE_MAX) :
                RST_ZERO;
        end

        // datapath reset pulse when fine delay is switched on
        if (fine_on_edge)
        begin
            s_nxt.dp_cnt = DP_RST_CYCLES;
        end
        else if (s_r.dp_cnt != 3'h0)
        begin
            s_nxt.dp_cnt = s_r.dp_cnt - 3'h1;
        end
        s_nxt.dp_rst = (s_nxt.dp_cnt != 3'h0);

        // duty stabilizers
        s_nxt.stab_on = {s_nxt.stab_b[DUTY_STAB_EN_BIT],
                         s_nxt.stab_a[DUTY_STAB_EN_BIT]};

        // power-down and standby; delay writes never touch the link
        pd_now = (power_control_pin &&
                  s_r.pwr_b[1:0] == PIN_FN_PDOWN) ||
                 s_r.pwr_a[1:0] == PWR_DOWN;
        sb_now = !pd_now &&
                 ((power_control_pin &&
                   s_r.pwr_b[1:0] == PIN_FN_STANDBY) ||
                  s_r.pwr_a[1:0] == PWR_STANDBY);
        s_nxt.pdown   = pd_now;
        s_nxt.link_up = !pd_now;
        s_nxt.stby    = sb_now;
        s_nxt.fill_k  = sb_now && s_r.fill[FILL_K_BIT];

        // reference pin exports
        case (s_r.diode)
            DIODE_SMALL: s_nxt.diode_out = 2'h1;
            DIODE_LARGE: s_nxt.diode_out = 2'h2;
            default:     s_nxt.diode_out = 2'h0;
        endcase
        s_nxt.cm_on  = s_r.cmx[CM_EXPORT_BIT];
        s_nxt.ref_on = s_r.refx[REF_EXPORT_BIT];
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            s_r         <= '0;
            s_r.chsel   <= RST_CHANNEL_SELECT;
            s_r.stab_a  <= stab_reset(HIGH_GRADE);
            s_r.stab_b  <= stab_reset(HIGH_GRADE);
            s_r.stab_on <= {2{HIGH_GRADE}};
            s_r.div_tick <= 1'b1;
            s_r.link_up <= 1'b1;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign reg_rdata              = s_r.rdata;
    assign div_tick               = s_r.div_tick;
    assign div_phase              = s_r.div_cnt;
    assign ch_dly                 = s_r.dly;
    assign duty_stabilizer_on     = s_r.stab_on;
    assign dp_reset               = s_r.dp_rst;
    assign link_up                = s_r.link_up;
    assign standby_active         = s_r.stby;
    assign fill_k_chars           = s_r.fill_k;
    assign power_down_state       = s_r.pdown;
    assign diode_export           = s_r.diode_out;
    assign common_mode_voltage_on = s_r.cm_on;
    assign ref_export_on          = s_r.ref_on;

    ////////////////////////////////////////////////////////////////////////
    // checks

    a_div_two_alt: assert property (
        @(posedge clk) disable iff (!rst_n)
        (s_r.div_cfg[1:0] == DIV_BY_2 && div_tick && !sysref_in && !req.wr)
        |=> !div_tick)
        else $error("divide by two ticked twice in a row");

    a_div_four_gap: assert property (
        @(posedge clk) disable iff (!rst_n)
        (s_r.div_cfg[1:0] == DIV_BY_4 && div_tick &&
         !sysref_in && !req.wr) ##1 (!sysref_in && !req.wr) [*3]
        |=> div_tick)
        else $error("divide by four tick not after four cycles");

    a_sysref_align: assert property (
        @(posedge clk) disable iff (!rst_n)
        (sysref_in && s_r.div_cfg[DIV_SYNC_EN_BIT] && !req.wr)
        |=> div_phase ==
            ($past(s_r.div_cfg[5:4]) & div_last($past(s_r.div_cfg[1:0]))))
        else $error("sysref did not load divider phase");

    a_half_delay: assert property (
        @(posedge clk) disable iff (!rst_n)
        (req.wr && req.addr == ADDR_HALF_PHASE_DLY)
        |=> ch_dly[0].half_en == $past(req.wdata[0]) &&
            ch_dly[1].half_en == $past(req.wdata[1]))
        else $error("half period delay not applied next cycle");

    a_link_undisturbed: assert property (
        @(posedge clk) disable iff (!rst_n)
        (req.wr && (req.addr == ADDR_HALF_PHASE_DLY ||
                    req.addr == ADDR_FINE_DLY ||
                    req.addr == ADDR_SUPERFINE_DLY) &&
         $stable(power_control_pin) && $stable(s_r.pwr_a) &&
         $stable(s_r.pwr_b))
        |=> $stable(link_up))
        else $error("delay write disturbed the link");

    a_superfine_gate: assert property (
        @(posedge clk) disable iff (!rst_n)
        ch_dly[0].sfine_en == sf_mode(s_r.mode[0]) &&
        (!ch_dly[0].sfine_en -> ch_dly[0].sfine == 8'h00))
        else $error("superfine active outside modes 2 and 6");

    a_fine_range: assert property (
        @(posedge clk) disable iff (!rst_n)
        ch_dly[1].fine <= FINE_MAX_192 &&
        ch_dly[1].sfine <= SUPERFINE_MAX)
        else $error("delay value beyond step range");

    a_dp_reset_pulse: assert property (
        @(posedge clk) disable iff (!rst_n)
        (req.wr && req.addr == ADDR_CLK_DLY_MODE && s_r.chsel[0] &&
         s_r.mode[0][2:0] == 3'h0 && req.wdata[2:0] != 3'h0)
        |=> dp_reset [*4] ##1 (!dp_reset || $past(req.wr)))
        else $error("datapath reset pulse wrong length");

    a_pin_pdown: assert property (
        @(posedge clk) disable iff (!rst_n)
        (power_control_pin && s_r.pwr_b[1:0] == 2'h0)
        |=> !link_up && power_down_state && !standby_active)
        else $error("pin did not power down and drop link");

    a_standby_fill: assert property (
        @(posedge clk) disable iff (!rst_n)
        standby_active |-> link_up &&
        fill_k_chars == $past(s_r.fill[7]))
        else $error("standby link or fill select wrong");

    a_diode_route: assert property (
        @(posedge clk) disable iff (!rst_n)
        (req.wr && req.addr == ADDR_DIODE_EXPORT && req.wdata == 8'h02)
        |=> ##1 diode_export == 2'h2)
        else $error("large diode not routed after write");

    a_diode_small: assert property (
        @(posedge clk) disable iff (!rst_n)
        (req.wr && req.addr == ADDR_DIODE_EXPORT && req.wdata == DIODE_SMALL)
        |=> ##1 diode_export == 2'h1)
        else $error("small diode not routed after write");

    a_fine_steps16: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ch_dly[1].fine_en && !ch_dly[1].fine_192)
        |-> ch_dly[1].fine <= FINE_MAX_16)
        else $error("sixteen step fine delay beyond range");

    a_reg_pdown: assert property (
        @(posedge clk) disable iff (!rst_n)
        (s_r.pwr_a[1:0] == PWR_DOWN)
        |=> !link_up && power_down_state && !standby_active)
        else $error("register power-down kept the link up");

    a_div_one_tick: assert property (
        @(posedge clk) disable iff (!rst_n)
        (s_r.div_cfg[1:0] == DIV_BY_1)
        |=> div_tick)
        else $error("divide by one missed a tick");

endmodule

/* File: sim/acdp_sysref_src.sv */
// sysref source model: one-cycle pulse on request
`timescale 1ns/1ps

module acdp_sysref_src
(
    // clock and request
    input  wire logic clk,
    input  wire logic fire,
    // pulse to the device
    output logic      sysref = 1'b0
);
    logic armed_r = 1'b0;
    always @(posedge clk) armed_r <= fire;
    always @(negedge clk) sysref <= armed_r;
endmodule

/* File: sim/testbench.sv */
// self-checking bench for divider, delay, power and export control
`timescale 1ns/1ps

module testbench;
    import acdp_pkg::*;
    logic            clk = 1'b0;
    logic            rst_n = 1'b0;
    logic            pin = 1'b0;
    logic            fire = 1'b0;
    logic            rd_taken = 1'b0;
    acdp_req_t       req = '0;
    logic [7:0]      reg_rdata, n, v, q[$];
    logic            sysref_in, div_tick, dp_reset, link_up, stby, fill;
    logic            pd, cm_on, ref_on;
    logic [1:0]      div_phase, dso, dso_lo, diode, ph;
    acdp_dly_t [1:0] ch_dly;
    int              errors = 0, n_tests = 0, dp_n = 0;
    localparam logic [15:0] AT [13] = '{ADDR_POWER_CTRL_A,
        ADDR_POWER_CTRL_B, ADDR_CLK_DIV_RATIO, ADDR_HALF_PHASE_DLY,
        ADDR_CLK_DLY_MODE, ADDR_SUPERFINE_DLY, ADDR_FINE_DLY,
        ADDR_DUTY_STAB_A, ADDR_DUTY_STAB_B, ADDR_STBY_FILL_SEL,
        ADDR_REF_EXPORT, ADDR_CM_EXPORT, ADDR_DIODE_EXPORT};
    localparam logic [2:0] MD [4] = '{3'h1, 3'h2, 3'h4, 3'h6};

    always #20 clk = ~clk;

    acdp_sysref_src i_acdp_sysref_src (.clk(clk), .fire(fire),
        .sysref(sysref_in));

    acdp_ctrl #(.HIGH_GRADE(1'b1)) i_acdp_ctrl (.clk(clk), .rst_n(rst_n),
        .req(req), .reg_rdata(reg_rdata), .sysref_in(sysref_in),
        .div_tick(div_tick), .div_phase(div_phase), .ch_dly(ch_dly),
        .duty_stabilizer_on(dso), .dp_reset(dp_reset),
        .power_control_pin(pin), .link_up(link_up), .standby_active(stby),
        .fill_k_chars(fill), .power_down_state(pd), .diode_export(diode),
        .common_mode_voltage_on(cm_on), .ref_export_on(ref_on));

    acdp_ctrl #(.HIGH_GRADE(1'b0)) i_acdp_ctrl_lo (.clk(clk),
        .rst_n(rst_n), .req(req), .reg_rdata(), .sysref_in(sysref_in),
        .div_tick(), .div_phase(), .ch_dly(), .duty_stabilizer_on(dso_lo),
        .dp_reset(), .power_control_pin(pin), .link_up(), .standby_active(),
        .fill_k_chars(), .power_down_state(), .diode_export(),
        .common_mode_voltage_on(), .ref_export_on());

    ////////////////////////////////////////////////////////////////////////
    task tally_and_finish;
        $display("tests %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        @(negedge clk);
        req.wr = 1'b0;
        @(negedge clk);
    endtask

    task rd(input logic [15:0] a, input logic [7:0] e);
        @(negedge clk);
        req.rd = 1'b1;
        req.addr = a;
        q.push_back(e);
        @(negedge clk);
        req.rd = 1'b0;
    endtask

    function automatic logic [7:0] pw();
        return {4'h0, link_up, stby, fill, pd};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk) rd_taken <= req.rd && rst_n;
    always @(negedge clk) if (dp_reset === 1'b1) dp_n++;
    always @(negedge clk)
        if (rd_taken && q.size() > 0)
            chk(reg_rdata, q.pop_front());

    initial
    begin
        repeat (5000) @(posedge clk);
        errors++;
        tally_and_finish();
    end

    initial
    begin
        v = 8'($urandom(32'haffe5d8a));
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        chk(8'(dso), 8'h03);
        chk(8'(dso_lo), 8'h00);
        rd(ADDR_CHANNEL_SELECT, RST_CHANNEL_SELECT);
        foreach (AT[i])
            rd(AT[i], AT[i] inside {ADDR_DUTY_STAB_A, ADDR_DUTY_STAB_B}
                ? RST_DUTY_STAB_ON : RST_ZERO);
        rd(16'h0200, 8'h00);
        foreach (AT[i])
        begin
            v = 8'($urandom) & (AT[i] == ADDR_CLK_DLY_MODE ? 8'h07 : 8'hFF);
            wr(AT[i], v);
            rd(AT[i], v);
        end
        foreach (AT[i]) wr(AT[i], 8'h00);
        chk(8'(dso), 8'h00);
        wr(ADDR_DUTY_STAB_A, 8'h01);
        wr(ADDR_DUTY_STAB_B, 8'h01);
        chk(8'(dso), 8'h03);
        for (int c = 0; c < 4; c++)
        begin
            wr(ADDR_CLK_DIV_RATIO, 8'(c));
            n = 0;
            repeat (8) @(negedge clk) n += 8'(div_tick);
            chk(n, c == 1 ? 8'h04 : c == 2 ? 8'h02 : 8'h08);
        end
        for (int p = 0; p < 5; p++)
        begin
            wr(ADDR_CLK_DIV_RATIO, p < 4 ? 8'(8'h82 | (p << 4)) : 8'h22);
            @(negedge clk);
            fire = 1'b1;
            ph = div_phase;
            @(negedge clk);
            fire = 1'b0;
            @(negedge clk);
            chk(8'(div_phase), p < 4 ? 8'(p) : 8'(2'(ph + 2'h2)));
        end
        wr(ADDR_HALF_PHASE_DLY, 8'h01);
        chk({ch_dly[1].half_en, ch_dly[0].half_en, link_up}, 8'h03);
        foreach (MD[i])
        begin
            wr(ADDR_CLK_DLY_MODE, 8'h00);
            wr(ADDR_FINE_DLY, 8'hFF);
            wr(ADDR_SUPERFINE_DLY, 8'hFF);
            repeat (6) @(negedge clk);
            dp_n = 0;
            wr(ADDR_CLK_DLY_MODE, 8'(MD[i]));
            repeat (8) @(negedge clk);
            chk(8'(dp_n), 8'h04);
            for (int j = 0; j < 2; j++)
            begin
                chk(ch_dly[j].fine, MD[i][2] ? FINE_MAX_192 : FINE_MAX_16);
                chk({ch_dly[j].fine_en, ch_dly[j].fine_192}, {7'h01, MD[i][2]});
                chk(ch_dly[j].sfine, MD[i][1] ? SUPERFINE_MAX : 8'h00);
                chk(8'(ch_dly[j].sfine_en), 8'(MD[i][1]));
            end
            chk(8'(link_up), 8'h01);
        end
        pin = 1'b1;
        repeat (3) @(negedge clk);
        chk(pw(), 8'h01);
        wr(ADDR_POWER_CTRL_B, 8'h01);
        chk(pw(), 8'h0C);
        wr(ADDR_STBY_FILL_SEL, 8'h80);
        chk(pw(), 8'h0E);
        pin = 1'b0;
        wr(ADDR_POWER_CTRL_B, 8'h00);
        wr(ADDR_POWER_CTRL_A, 8'h03);
        chk(pw(), 8'h01);
        wr(ADDR_POWER_CTRL_A, 8'h02);
        chk(pw(), 8'h0E);
        wr(ADDR_POWER_CTRL_A, 8'h00);
        wr(ADDR_CHANNEL_SELECT, 8'h03);
        wr(ADDR_CM_EXPORT, 8'h00);
        wr(ADDR_REF_EXPORT, 8'h00);
        for (int d = 1; d < 4; d++)
        begin
            wr(ADDR_DIODE_EXPORT, 8'(d));
            chk(8'(diode), d < 3 ? 8'(d) : 8'h00);
        end
        wr(ADDR_DIODE_EXPORT, 8'h00);
        wr(ADDR_CM_EXPORT, 8'h40);
        wr(ADDR_REF_EXPORT, 8'h01);
        chk({cm_on, ref_on}, 8'h03);
        chk(8'(q.size()), 8'h00);
        tally_and_finish();
    end
endmodule
